// ==== hdl/bsfm_pkg.sv ====
// Purpose: shared constants and types of the bidirectional mailbox buffer
// Assumes: all logic runs on ref_clk; port clocks are sampled as data
// Notes: offsets are words; presets are picked by the two offset selects
package bsfm_pkg;
    localparam int DATA_W = 36;
    localparam int DEPTH = 512;
    localparam int OFF_W = 11;
    localparam logic [1:0] SEL_PROGRAM = 2'h0;
    localparam logic [1:0] SEL_PRESET_A = 2'h1;
    localparam logic [1:0] SEL_PRESET_B = 2'h2;
    localparam logic [OFF_W-1:0] PRESET_A = 11'h008;
    localparam logic [OFF_W-1:0] PRESET_B = 11'h010;
    localparam logic [OFF_W-1:0] PRESET_C = 11'h040;
    localparam logic [OFF_W-1:0] OFFSET_RST = 11'h008;
    localparam logic [1:0] ARM_DONE = 2'h2;

    typedef struct packed {
        logic clk;
        logic chip_sel_n;
        logic enable;
        logic dir;
        logic mailbox;
        logic [DATA_W-1:0] data;
    } bsfm_port_t;

    typedef struct packed {
        logic fwd_rst_n;
        logic rev_rst_n;
        logic sel_hi;
        logic sel_lo;
    } bsfm_ctl_t;

    typedef enum logic [4:0] {
        PROG_IDLE = 5'h01,
        PROG_FWD_EMPTY = 5'h02,
        PROG_REV_EMPTY = 5'h04,
        PROG_FWD_FULL = 5'h08,
        PROG_REV_FULL = 5'h10
    } bsfm_prog_t;
endpackage : bsfm_pkg

// ==== hdl/bsfm_bidir_fifo.sv ====
// Purpose: two opposite queues with mailbox bypass between a left and a right port
// Assumes: port clocks are much slower than ref_clk and are sampled as pins
// Notes: every rising port edge becomes a one-cycle tick of ref_clk
//
// What this block does
// - almost-empty low when words at or below offset
// - almost-full low when free slots at or below offset
// - left transfers and flags timed by left clock edges
// - chip select low enables access, else outputs off
// - enable high required to move data
// - reset release latches offset selects, applies preset
// - select low on joint reset: four writes program offsets
// - input ready low in reset, rises second edge
// - left output ready rises third edge after word
// - right output ready rises third edge after word
// - left mailbox select picks reverse mailbox or queue
// - right mailbox select picks forward mailbox or queue
// - left mailbox write empties flag, blocks writes
// - right mailbox read or forward reset frees mailbox
// - reverse mailbox set by right, freed by left
// - left direction high writes, low reads
// - right direction low writes, high reads
// - reset clears pointers and sets flag levels
// - flags pass two stages to their port clock
// - each queue 36 bits wide, configurable depth
// - both selects high preset offset 64
`timescale 1ns/1ps

module bsfm_sync #(parameter int W = 1) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sampled pins
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            dout <= '0;
        end else begin
            s1_q <= din;
            dout <= s1_q;
        end
    end
endmodule : bsfm_sync

module bsfm_queue #(parameter int DEPTH = bsfm_pkg::DEPTH) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic queue_rst_n,
    // writing port
    input wire logic wr_tick,
    input wire logic wr_req,
    input wire logic [bsfm_pkg::DATA_W-1:0] wr_data,
    input wire logic [bsfm_pkg::OFF_W-1:0] full_off,
    output logic in_ready,
    output logic almost_full_n,
    // reading port
    input wire logic rd_tick,
    input wire logic rd_req,
    input wire logic [bsfm_pkg::OFF_W-1:0] empty_off,
    output logic out_ready,
    output logic almost_empty_n,
    output logic [bsfm_pkg::DATA_W-1:0] out_word
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    logic [bsfm_pkg::DATA_W-1:0] mem [DEPTH];
    logic [AW:0] wptr_q, wptr_d, rptr_q, rptr_d, wg1_q, wg1_d, wg2_q, wg2_d, rg1_q, rg1_d, rg2_q, rg2_d;
    logic [AW:0] wsync, rsync, used, held;
    logic [1:0] arm_q, arm_d;
    logic ir_d, or_d, ae_d, af_d, do_wr, do_rd, fetch;
    logic [bsfm_pkg::DATA_W-1:0] dout_d;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : to_gray

    function automatic logic [AW:0] from_gray(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : from_gray

    always_comb begin
        wsync = from_gray(wg2_q);
        rsync = from_gray(rg2_q);
        do_wr = wr_req && in_ready;
        do_rd = rd_req && out_ready;
        fetch = rd_tick && (wsync != rptr_q) && (!out_ready || do_rd);
        wptr_d = wptr_q + (AW+1)'(do_wr);
        rptr_d = rptr_q + (AW+1)'(fetch);
        used = wptr_d - rsync;
        held = wsync - rptr_d;
        {wg1_d, wg2_d, rg1_d, rg2_d, arm_d} = {wg1_q, wg2_q, rg1_q, rg2_q, arm_q};
        {ir_d, or_d, ae_d, af_d, dout_d} = {in_ready, out_ready, almost_empty_n, almost_full_n, out_word};
        if (wr_tick) begin
            rg1_d = to_gray(rptr_q);
            rg2_d = rg1_q;
            arm_d = (arm_q == bsfm_pkg::ARM_DONE) ? arm_q : arm_q + 2'h1;
            ir_d = (arm_q != 2'h0) && (used != DEPTH_C);
            af_d = bsfm_pkg::OFF_W'(DEPTH_C - used) > full_off;
        end
        if (rd_tick) begin
            wg1_d = to_gray(wptr_q);
            wg2_d = wg1_q;
            or_d = fetch || (out_ready && !do_rd);
            dout_d = fetch ? mem[rptr_q[AW-1:0]] : out_word;
            ae_d = (bsfm_pkg::OFF_W'(held) + bsfm_pkg::OFF_W'(or_d)) > empty_off;
        end
        if (!queue_rst_n) begin
            wptr_d = '0;
            rptr_d = '0;
            {wg1_d, wg2_d, rg1_d, rg2_d, arm_d} = '0;
            {ir_d, or_d, ae_d, af_d} = 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            {wptr_q, rptr_q, wg1_q, wg2_q, rg1_q, rg2_q, arm_q} <= '0;
            {in_ready, out_ready, almost_empty_n, almost_full_n} <= 4'h1;
            out_word <= '0;
        end else begin
            {wptr_q, rptr_q, wg1_q, wg2_q, rg1_q, rg2_q, arm_q} <= {wptr_d, rptr_d, wg1_d, wg2_d, rg1_d, rg2_d, arm_d};
            {in_ready, out_ready, almost_empty_n, almost_full_n} <= {ir_d, or_d, ae_d, af_d};
            out_word <= dout_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (do_wr) begin
            mem[wptr_q[AW-1:0]] <= wr_data;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_reset_flags;
        !queue_rst_n |=> !in_ready && !out_ready && !almost_empty_n && almost_full_n;
    endproperty
    a_reset_flags: assert property (p_reset_flags) else $error("queue reset flag levels wrong");

    property p_ready_second_edge;
        $rose(in_ready) |-> $past(arm_q) != 2'h0 && $past(wr_tick);
    endproperty
    a_ready_second_edge: assert property (p_ready_second_edge) else $error("input ready rose too early");

    property p_full_write_blocked;
        queue_rst_n && wr_req && !in_ready |=> wptr_q == $past(wptr_q);
    endproperty
    a_full_write_blocked: assert property (p_full_write_blocked) else $error("write moved full queue");

    property p_ready_needs_word;
        $rose(out_ready) |-> $past(wsync != rptr_q) && $past(rd_tick);
    endproperty
    a_ready_needs_word: assert property (p_ready_needs_word) else $error("output ready without data");

    property p_empty_flag_low;
        queue_rst_n && rd_tick && !out_ready && wsync == rptr_q |=> !almost_empty_n;
    endproperty
    a_empty_flag_low: assert property (p_empty_flag_low) else $error("almost empty high on empty queue");
endmodule : bsfm_queue

module bsfm_bidir_fifo #(parameter int DEPTH = bsfm_pkg::DEPTH) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // left port pins
    input wire logic left_port_clock,
    input wire logic left_chip_select_n,
    input wire logic left_port_enable,
    input wire logic left_write_not_read,
    input wire logic left_mailbox_select,
    input wire logic [bsfm_pkg::DATA_W-1:0] left_data_in,
    output logic [bsfm_pkg::DATA_W-1:0] left_data_out,
    output logic left_data_oe,
    // right port pins
    input wire logic right_port_clock,
    input wire logic right_chip_select_n,
    input wire logic right_port_enable,
    input wire logic right_read_not_write,
    input wire logic right_mailbox_select,
    input wire logic [bsfm_pkg::DATA_W-1:0] right_data_in,
    output logic [bsfm_pkg::DATA_W-1:0] right_data_out,
    output logic right_data_oe,
    // queue resets and offset selects
    input wire logic fwd_queue_reset_n,
    input wire logic rev_queue_reset_n,
    input wire logic offset_select_lo,
    input wire logic offset_select_hi,
    // flags
    output logic left_input_ready,
    output logic left_output_ready,
    output logic left_almost_empty_n,
    output logic left_almost_full_n,
    output logic right_input_ready,
    output logic right_output_ready,
    output logic right_almost_empty_n,
    output logic right_almost_full_n,
    output logic fwd_mailbox_full_n,
    output logic rev_mailbox_full_n
);
    bsfm_pkg::bsfm_port_t lp, rp;
    bsfm_pkg::bsfm_ctl_t cc;
    bsfm_pkg::bsfm_prog_t prog_q, prog_d;
    logic lclk_q, rclk_q, frst_q, rrst_q, ltick, rtick, l_wr, l_rd, r_wr, r_rd, frise, rrise;
    logic fmb_full_d, rmb_full_d, l_oe_d, r_oe_d;
    logic [1:0] sel;
    logic [bsfm_pkg::DATA_W-1:0] fmb_q, fmb_d, rmb_q, rmb_d, l_out_d, r_out_d, fwd_word, rev_word;
    logic [bsfm_pkg::OFF_W-1:0] fe_q, fe_d, re_q, re_d, ff_q, ff_d, rf_q, rf_d;

    bsfm_sync #(.W($bits(bsfm_pkg::bsfm_port_t))) u_left_sync (.clk(ref_clk), .rst_n(reset_n),
        .din({left_port_clock, left_chip_select_n, left_port_enable, left_write_not_read,
              left_mailbox_select, left_data_in}), .dout(lp));
    bsfm_sync #(.W($bits(bsfm_pkg::bsfm_port_t))) u_right_sync (.clk(ref_clk), .rst_n(reset_n),
        .din({right_port_clock, right_chip_select_n, right_port_enable, right_read_not_write,
              right_mailbox_select, right_data_in}), .dout(rp));
    bsfm_sync #(.W($bits(bsfm_pkg::bsfm_ctl_t))) u_ctl_sync (.clk(ref_clk), .rst_n(reset_n),
        .din({fwd_queue_reset_n, rev_queue_reset_n, offset_select_hi, offset_select_lo}), .dout(cc));

    function automatic logic [bsfm_pkg::OFF_W-1:0] preset(input logic [1:0] s);
        return (s == bsfm_pkg::SEL_PRESET_A) ? bsfm_pkg::PRESET_A :
               (s == bsfm_pkg::SEL_PRESET_B) ? bsfm_pkg::PRESET_B : bsfm_pkg::PRESET_C;
    endfunction : preset

    // port edge ticks and access decode
    always_comb begin
        ltick = lp.clk && !lclk_q;
        rtick = rp.clk && !rclk_q;
        l_wr = ltick && !lp.chip_sel_n && lp.enable && lp.dir;
        l_rd = ltick && !lp.chip_sel_n && lp.enable && !lp.dir;
        r_wr = rtick && !rp.chip_sel_n && rp.enable && !rp.dir;
        r_rd = rtick && !rp.chip_sel_n && rp.enable && rp.dir;
        frise = cc.fwd_rst_n && !frst_q;
        rrise = cc.rev_rst_n && !rrst_q;
        sel = {cc.sel_hi, cc.sel_lo};
    end

    bsfm_queue #(.DEPTH(DEPTH)) u_fwd (.ref_clk(ref_clk), .reset_n(reset_n), .queue_rst_n(cc.fwd_rst_n),
        .wr_tick(ltick), .wr_req(l_wr && !lp.mailbox && prog_q == bsfm_pkg::PROG_IDLE), .wr_data(lp.data),
        .full_off(ff_q), .in_ready(left_input_ready), .almost_full_n(left_almost_full_n),
        .rd_tick(rtick), .rd_req(r_rd && !rp.mailbox), .empty_off(fe_q), .out_ready(right_output_ready),
        .almost_empty_n(right_almost_empty_n), .out_word(fwd_word));
    bsfm_queue #(.DEPTH(DEPTH)) u_rev (.ref_clk(ref_clk), .reset_n(reset_n), .queue_rst_n(cc.rev_rst_n),
        .wr_tick(rtick), .wr_req(r_wr && !rp.mailbox), .wr_data(rp.data),
        .full_off(rf_q), .in_ready(right_input_ready), .almost_full_n(right_almost_full_n),
        .rd_tick(ltick), .rd_req(l_rd && !lp.mailbox), .empty_off(re_q), .out_ready(left_output_ready),
        .almost_empty_n(left_almost_empty_n), .out_word(rev_word));

    // mailboxes, offsets and output drive
    always_comb begin
        {fmb_d, fmb_full_d, rmb_d, rmb_full_d} = {fmb_q, fwd_mailbox_full_n, rmb_q, rev_mailbox_full_n};
        {fe_d, re_d, ff_d, rf_d} = {fe_q, re_q, ff_q, rf_q};
        prog_d = prog_q;
        if (r_rd && rp.mailbox) begin
            fmb_full_d = 1'b1;
        end
        if (l_wr && lp.mailbox && fwd_mailbox_full_n) begin
            fmb_d = lp.data;
            fmb_full_d = 1'b0;
        end
        if (!cc.fwd_rst_n) begin
            fmb_full_d = 1'b1;
        end
        if (l_rd && lp.mailbox) begin
            rmb_full_d = 1'b1;
        end
        if (r_wr && rp.mailbox && rev_mailbox_full_n) begin
            rmb_d = rp.data;
            rmb_full_d = 1'b0;
        end
        if (!cc.rev_rst_n) begin
            rmb_full_d = 1'b1;
        end
        if (frise && sel != bsfm_pkg::SEL_PROGRAM) begin
            fe_d = preset(sel);
            ff_d = preset(sel);
        end
        if (rrise && sel != bsfm_pkg::SEL_PROGRAM) begin
            re_d = preset(sel);
            rf_d = preset(sel);
        end
        if (frise && rrise && sel == bsfm_pkg::SEL_PROGRAM) begin
            prog_d = bsfm_pkg::PROG_FWD_EMPTY;
        end else if (l_wr && !lp.mailbox && left_input_ready) begin
            case (prog_q)
                bsfm_pkg::PROG_IDLE: begin
                    prog_d = bsfm_pkg::PROG_IDLE;
                end
                bsfm_pkg::PROG_FWD_EMPTY: begin
                    fe_d = lp.data[bsfm_pkg::OFF_W-1:0];
                    prog_d = bsfm_pkg::PROG_REV_EMPTY;
                end
                bsfm_pkg::PROG_REV_EMPTY: begin
                    re_d = lp.data[bsfm_pkg::OFF_W-1:0];
                    prog_d = bsfm_pkg::PROG_FWD_FULL;
                end
                bsfm_pkg::PROG_FWD_FULL: begin
                    ff_d = lp.data[bsfm_pkg::OFF_W-1:0];
                    prog_d = bsfm_pkg::PROG_REV_FULL;
                end
                bsfm_pkg::PROG_REV_FULL: begin
                    rf_d = lp.data[bsfm_pkg::OFF_W-1:0];
                    prog_d = bsfm_pkg::PROG_IDLE;
                end
                default: begin
                    prog_d = bsfm_pkg::PROG_IDLE;
                end
            endcase
        end
        l_oe_d = !lp.chip_sel_n && !lp.dir;
        r_oe_d = !rp.chip_sel_n && rp.dir;
        l_out_d = lp.mailbox ? rmb_q : rev_word;
        r_out_d = rp.mailbox ? fmb_q : fwd_word;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            {lclk_q, rclk_q, frst_q, rrst_q} <= 4'h0;
            {fmb_q, rmb_q, left_data_out, right_data_out} <= '0;
            {fwd_mailbox_full_n, rev_mailbox_full_n, left_data_oe, right_data_oe} <= 4'hC;
            {fe_q, re_q, ff_q, rf_q} <= {4{bsfm_pkg::OFFSET_RST}};
            prog_q <= bsfm_pkg::PROG_IDLE;
        end else begin
            {lclk_q, rclk_q, frst_q, rrst_q} <= {lp.clk, rp.clk, cc.fwd_rst_n, cc.rev_rst_n};
            {fmb_q, rmb_q, left_data_out, right_data_out} <= {fmb_d, rmb_d, l_out_d, r_out_d};
            {fwd_mailbox_full_n, rev_mailbox_full_n, left_data_oe, right_data_oe} <= {fmb_full_d, rmb_full_d, l_oe_d, r_oe_d};
            {fe_q, re_q, ff_q, rf_q} <= {fe_d, re_d, ff_d, rf_d};
            prog_q <= prog_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_fwd_mail_set;
        cc.fwd_rst_n && l_wr && lp.mailbox && fwd_mailbox_full_n |=> !fwd_mailbox_full_n && fmb_q == $past(lp.data);
    endproperty
    a_fwd_mail_set: assert property (p_fwd_mail_set) else $error("forward mailbox write not taken");

    property p_fwd_mail_free;
        !fwd_mailbox_full_n && r_rd && rp.mailbox |=> fwd_mailbox_full_n;
    endproperty
    a_fwd_mail_free: assert property (p_fwd_mail_free) else $error("forward mailbox not freed");

    property p_rev_mail_hold;
        !rev_mailbox_full_n && cc.rev_rst_n && !(l_rd && lp.mailbox) |=> !rev_mailbox_full_n && $stable(rmb_q);
    endproperty
    a_rev_mail_hold: assert property (p_rev_mail_hold) else $error("reverse mailbox changed while full");

    property p_left_drive;
        left_data_oe |-> $past(!lp.chip_sel_n && !lp.dir);
    endproperty
    a_left_drive: assert property (p_left_drive) else $error("left data driven without read select");

    property p_right_drive;
        right_data_oe |-> $past(!rp.chip_sel_n && rp.dir);
    endproperty
    a_right_drive: assert property (p_right_drive) else $error("right data driven without read select");

    property p_preset_top;
        frise && sel == 2'h3 |=> fe_q == bsfm_pkg::PRESET_C && ff_q == bsfm_pkg::PRESET_C;
    endproperty
    a_preset_top: assert property (p_preset_top) else $error("preset offset not loaded");

    property p_right_mail_out;
        right_data_oe && $past(rp.mailbox) |-> right_data_out == $past(fmb_q);
    endproperty
    a_right_mail_out: assert property (p_right_mail_out) else $error("right mailbox data wrong");
endmodule : bsfm_bidir_fifo

// ==== tb/bsfm_port_host.sv ====
// Purpose: host model for one port of the mailbox buffer
// Assumes: ref_clk runs much faster than the port clock made here
// Notes: pins change right after a ref_clk edge and are held a whole port cycle
`timescale 1ns/1ps

module bsfm_port_host #(parameter int PERIOD = 8, parameter bit RD_HIGH = 1'b0) (
    // clock
    input wire logic ref_clk,
    // port pins
    output logic port_clk,
    output logic chip_sel_n,
    output logic enable,
    output logic dir,
    output logic mbox_sel,
    output logic [bsfm_pkg::DATA_W-1:0] data_in,
    // device side of the bus
    input wire logic [bsfm_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe
);
    int cnt = 0;
    logic [bsfm_pkg::DATA_W-1:0] host_q = '0;
    logic host_oe = 1'b0;

    initial begin
        chip_sel_n = 1'b1;
        enable = 1'b0;
        dir = RD_HIGH;
        mbox_sel = 1'b0;
    end

    // free running port clock
    always @(posedge ref_clk) begin
        cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    end
    assign port_clk = (cnt >= PERIOD / 2);

    // resolved bus level; a released bus shows the inverse of its last value
    assign data_in = data_oe ? data_out : (host_oe ? host_q : ~host_q);

    // one access: set up after the falling edge, sample at the rising edge
    task automatic xfer(input logic wr, input logic mb, input logic cs_n, input logic en,
                        input logic [bsfm_pkg::DATA_W-1:0] d, output logic [bsfm_pkg::DATA_W-1:0] q,
                        output logic oe);
        do @(posedge ref_clk); while (cnt != PERIOD - 1);
        chip_sel_n <= cs_n;
        enable <= en;
        dir <= wr ^ RD_HIGH;
        mbox_sel <= mb;
        host_q <= d;
        host_oe <= wr;
        do @(posedge ref_clk); while (cnt != PERIOD / 2 - 1);
        q = data_out;
        oe = data_oe;
        do @(posedge ref_clk); while (cnt != PERIOD - 1);
        chip_sel_n <= 1'b1;
        enable <= 1'b0;
        host_oe <= 1'b0;
    endtask : xfer
endmodule : bsfm_port_host

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the bidirectional mailbox buffer
// Assumes: two port hosts make slow port clocks from ref_clk
// Notes: depth cut to 256 words to keep the run short
`timescale 1ns/1ps

module tb;
    localparam int W = bsfm_pkg::DATA_W;
    localparam int D = 256;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic fwd_rst_n = 1'b0;
    logic rev_rst_n = 1'b0;
    logic sel_hi = 1'b0;
    logic sel_lo = 1'b0;
    logic lclk, lcs_n, len, ldir, lmb, loe, rclk, rcs_n, ren, rdir, rmb, roe, oe;
    logic [W-1:0] ldi, ldo, rdi, rdo, q;
    logic l_ir, l_or, l_ae_n, l_af_n, r_ir, r_or, r_ae_n, r_af_n, f_mb_n, r_mb_n;
    int fail_count = 0;
    int checks = 0;

    always #25 ref_clk = ~ref_clk;

    bsfm_port_host #(.PERIOD(8), .RD_HIGH(1'b0)) i_left (.ref_clk(ref_clk), .port_clk(lclk),
        .chip_sel_n(lcs_n), .enable(len), .dir(ldir), .mbox_sel(lmb), .data_in(ldi), .data_out(ldo), .data_oe(loe));
    bsfm_port_host #(.PERIOD(10), .RD_HIGH(1'b1)) i_right (.ref_clk(ref_clk), .port_clk(rclk),
        .chip_sel_n(rcs_n), .enable(ren), .dir(rdir), .mbox_sel(rmb), .data_in(rdi), .data_out(rdo), .data_oe(roe));

    bsfm_bidir_fifo #(.DEPTH(D)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .left_port_clock(lclk), .left_chip_select_n(lcs_n), .left_port_enable(len), .left_write_not_read(ldir),
        .left_mailbox_select(lmb), .left_data_in(ldi), .left_data_out(ldo), .left_data_oe(loe),
        .right_port_clock(rclk), .right_chip_select_n(rcs_n), .right_port_enable(ren),
        .right_read_not_write(rdir), .right_mailbox_select(rmb), .right_data_in(rdi), .right_data_out(rdo),
        .right_data_oe(roe), .fwd_queue_reset_n(fwd_rst_n), .rev_queue_reset_n(rev_rst_n),
        .offset_select_lo(sel_lo), .offset_select_hi(sel_hi), .left_input_ready(l_ir), .left_output_ready(l_or),
        .left_almost_empty_n(l_ae_n), .left_almost_full_n(l_af_n), .right_input_ready(r_ir),
        .right_output_ready(r_or), .right_almost_empty_n(r_ae_n), .right_almost_full_n(r_af_n),
        .fwd_mailbox_full_n(f_mb_n), .rev_mailbox_full_n(r_mb_n));

    task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle

    // one port access on the left or right host
    task automatic acc(input bit left, input logic wr, input logic mb, input logic cs_n, input logic en,
                       input logic [W-1:0] d);
        if (left) begin
            i_left.xfer(wr, mb, cs_n, en, d, q, oe);
        end else begin
            i_right.xfer(wr, mb, cs_n, en, d, q, oe);
        end
        idle(2);
    endtask : acc

    // joint reset of both queues with the given offset selects
    task automatic qreset(input logic hi, input logic lo);
        fwd_rst_n <= 1'b0;
        rev_rst_n <= 1'b0;
        sel_hi <= hi;
        sel_lo <= lo;
        idle(60);
        chk({l_ir, r_ir, l_or, r_or, l_ae_n, r_ae_n, l_af_n, r_af_n, f_mb_n, r_mb_n}, 36'h00F);
        fwd_rst_n <= 1'b1;
        rev_rst_n <= 1'b1;
        idle(4);
        chk({l_ir, r_ir}, 36'h0);
        idle(40);
        chk({l_ir, r_ir}, 36'h3);
    endtask : qreset

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    initial begin
        idle(50000);
        fail_count++;
        $display("Error %0t: watchdog expired", $time);
        end_sim();
    end

    initial begin
        idle(5);
        reset_n <= 1'b1;
        qreset(1'b0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, W'(k + 1));
        end
        acc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 36'h0_0000_0A01);
        idle(60);
        chk(r_ae_n, 36'h0);
        acc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 36'h0_0000_0A02);
        idle(60);
        chk({r_ae_n, r_or}, 36'h3);
        for (int k = 1; k < 3; k++) begin
            acc(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, '0);
            chk(q, W'(36'hA00 + k));
        end
        $display("test offset programming done");
        acc(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 36'h1_0000_0001);
        acc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 36'h2_0000_0002);
        chk({f_mb_n, r_mb_n}, 36'h0);
        qreset(1'b1, 1'b1);
        $display("test queue reset done");
        acc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 36'h3_0000_0003);
        chk(f_mb_n, 36'h1);
        acc(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 36'h3_0000_0003);
        chk(f_mb_n, 36'h1);
        acc(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 36'h4_0000_0004);
        chk({f_mb_n, oe}, 36'h0);
        acc(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 36'h5_0000_0005);
        acc(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, '0);
        chk(q, 36'h4_0000_0004);
        chk({oe, f_mb_n}, 36'h3);
        acc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 36'h6_0000_0006);
        chk({r_mb_n, oe}, 36'h0);
        acc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, '0);
        chk({oe, r_mb_n}, 36'h0);
        acc(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, '0);
        chk(q, 36'h6_0000_0006);
        chk({oe, r_mb_n}, 36'h3);
        $display("test mailbox done");
        // the output register holds one word beyond the memory depth
        for (int i = 0; i <= D; i++) begin
            if (i == 64 || i == 65) begin
                idle(60);
                chk(r_ae_n, 36'(i > 64));
            end
            acc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, {8'hA5, 28'(i)});
            chk(l_af_n, 36'(D - i > 64));
            chk(l_ir, 36'(i < D));
        end
        acc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, '1);
        idle(60);
        chk({l_ir, r_or}, 36'h1);
        for (int i = 0; i <= D; i++) begin
            acc(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, '0);
            chk(q, {8'hA5, 28'(i)});
        end
        idle(60);
        chk({r_or, r_ae_n}, 36'h0);
        acc(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, '0);
        acc(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 36'h7_0000_0007);
        idle(60);
        chk(l_or, 36'h1);
        acc(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, '0);
        chk(q, 36'h7_0000_0007);
        idle(60);
        chk(l_or, 36'h0);
        $display("test queues done");
        end_sim();
    end
endmodule : tb
